// ==== core/wqi_pkg.sv ====
package wqi_pkg;
	// command block word indices, as byte addresses = index * 4
	localparam logic [7:0]  OFS_CODE      = 8'h00;
	localparam logic [7:0]  OFS_CMD_OPT   = 8'h01;
	localparam logic [7:0]  OFS_STATUS    = 8'h02;
	localparam logic [7:0]  OFS_VECTORS   = 8'h04;
	localparam logic [7:0]  OFS_LEVEL     = 8'h05;
	localparam logic [7:0]  OFS_QNUM      = 8'h0e;
	localparam logic [7:0]  OFS_QOPT      = 8'h0f;
	localparam logic [7:0]  OFS_SLOTS     = 8'h10;
	localparam logic [7:0]  OFS_UNIT      = 8'h11;
	localparam logic [7:0]  OFS_TMO_HI    = 8'h12;
	localparam logic [7:0]  OFS_TMO_LO    = 8'h13;
	// own control/status words
	localparam logic [7:0]  OFS_GO        = 8'h20;
	localparam logic [7:0]  OFS_THAW      = 8'h21;
	localparam logic [7:0]  OFS_EVENT     = 8'h22;
	localparam logic [7:0]  OFS_QSTATE    = 8'h23;
	localparam logic [7:0]  OFS_VARIANT   = 8'h24;
	localparam logic [7:0]  OFS_RESULT    = 8'h25;
	localparam logic [7:0]  OFS_IRQ       = 8'h26;
	localparam logic [15:0] CMD_INIT_WQ   = 16'h0042;
	localparam int          BIT_IRQ_EN    = 0;
	localparam int          QO_ABORT      = 0;
	localparam int          QO_FREEZE     = 2;
	localparam int          QO_PARITY     = 3;
	localparam int          QO_SENSE      = 4;
	localparam int          QO_REPORT     = 5;
	localparam int          QO_FORCE      = 15;
	localparam int          UA_BUS        = 6;
	localparam int          UA_EXT        = 7;
	localparam int          RESP_FROZEN   = 3;
	localparam int          RESP_TIMEOUT  = 7;
	localparam logic [7:0]  QMAX_NARROW   = 8'h0e;
	localparam logic [7:0]  QMAX_WIDE     = 8'hff;
	localparam logic [7:0]  ERR_NONE      = 8'h00;
	localparam logic [7:0]  ERR_BAD_CODE  = 8'h01;
	localparam logic [7:0]  ERR_BAD_QUEUE = 8'h02;
	localparam logic [7:0]  ERR_PENDING   = 8'h03;
	localparam logic [7:0]  ERR_ALREADY   = 8'h04;
	localparam logic [7:0]  ERR_TIMEOUT   = 8'h05;
	localparam int          NQ            = 16;
	localparam int          TICK_MS       = 256;
	localparam int          CLK_MHZ       = 250;
	localparam int          TICK_CYC      = TICK_MS * 1000 * CLK_MHZ;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [15:0] RST_WORD      = 16'h0000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_DONE = 4'b0100,
		ST_RUN  = 4'b1000
	} wqi_state_e;

	typedef struct packed {
		logic [15:0] cmd_opt;
		logic [15:0] vectors;
		logic [2:0]  level;
		logic [7:0]  qnum;
		logic [15:0] qopt;
		logic [15:0] unit;
		logic [15:0] tmo;
	} wqi_block_s;

	typedef struct packed {
		logic [15:0] abort_en;
		logic [15:0] freeze_en;
		logic [15:0] parity_en;
		logic [15:0] sense_en;
		logic [15:0] report_en;
		logic [15:0] inited;
		logic [15:0] frozen;
		logic [15:0] bus_sel;
	} wqi_qflags_s;

	typedef struct packed {
		logic        irq;
		logic [2:0]  level;
		logic [7:0]  vector;
	} wqi_irq_s;
endpackage

// ==== core/wqi_core.sv ====
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module wqi_core #(
	parameter int TICK_CYCLES = wqi_pkg::TICK_CYC
) (
	// bus
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// engine events
	input  wire logic        wide_variant,
	input  wire logic [15:0] pending,
	input  wire logic        cmd_done,
	input  wire logic [3:0]  cmd_queue,
	input  wire logic [7:0]  cmd_scsi_status,
	input  wire logic        cmd_started,
	// queue controls
	output logic      [15:0] q_abort,
	output logic      [15:0] q_parity,
	output logic      [15:0] q_frozen,
	output logic      [15:0] q_bus_sel,
	output logic             sense_req,
	output logic             ctrl_err_irq,
	output logic      [2:0]  irq_level,
	output logic      [7:0]  irq_vector,
	output logic             irq
);
	typedef struct packed {
		wqi_pkg::wqi_state_e  st;
		logic                 wr_pend;
		logic                 rd_pend;
		logic [7:0]           addr;
		wqi_pkg::wqi_block_s  blk;
		logic [15:0]          code;
		logic [15:0]          status;
		logic [15:0]          resp_word;
		logic [15:0]          slots;
		logic [15:0]          thaw;
		wqi_pkg::wqi_qflags_s qf;
		// packed so the whole state stays one packed struct
		logic [wqi_pkg::NQ-1:0][15:0] tmo_q;
		logic [5:0]           ext_lun;
		logic [3:0]           ext_id;
		logic [15:0]          abort_p;
		logic                 sense_p;
		logic                 err_p;
		logic [3:0]           run_q;
		logic [15:0]          run_left;
		logic [31:0]          tick;
		wqi_pkg::wqi_irq_s    ir;
		logic [31:0]          rdata;
	} wqi_st_s;

	wqi_st_s r;
	wqi_st_s next_r;
	logic [3:0] q;

	function automatic logic q_bad(input logic [7:0] n, input logic w);
		q_bad = (n == 8'h00) || (n > (w ? wqi_pkg::QMAX_WIDE
			: wqi_pkg::QMAX_NARROW));
	endfunction

	assign q = r.blk.qnum[3:0];

	always_comb
	begin
		next_r = r;
		next_r.abort_p = '0;
		next_r.sense_p = 1'b0;
		next_r.err_p = 1'b0;
		next_r.ir.irq = 1'b0;
		if (r.wr_pend)
		begin
			next_r.wr_pend = 1'b0;
			case (r.addr)
				wqi_pkg::OFS_CODE:    next_r.code = hwdata[15:0];
				wqi_pkg::OFS_CMD_OPT: next_r.blk.cmd_opt = hwdata[15:0];
				wqi_pkg::OFS_VECTORS: next_r.blk.vectors = hwdata[15:0];
				wqi_pkg::OFS_LEVEL:   next_r.blk.level = hwdata[2:0];
				wqi_pkg::OFS_QNUM:    next_r.blk.qnum = hwdata[7:0];
				wqi_pkg::OFS_QOPT:    next_r.blk.qopt = hwdata[15:0];
				wqi_pkg::OFS_SLOTS:   next_r.slots = hwdata[15:0];
				wqi_pkg::OFS_UNIT:    next_r.blk.unit = hwdata[15:0];
				wqi_pkg::OFS_TMO_LO:  next_r.blk.tmo = hwdata[15:0];
				wqi_pkg::OFS_THAW:    next_r.thaw = hwdata[15:0];
				wqi_pkg::OFS_GO:
					if (hwdata[0] && r.st == wqi_pkg::ST_IDLE)
						next_r.st = wqi_pkg::ST_EXEC;
				default: ;
			endcase
		end
		if (r.rd_pend)
			next_r.rd_pend = 1'b0;
		// thaw: clear frozen bit, then the whole register
		if (r.thaw[0])
		begin
			next_r.qf.frozen[r.thaw[11:8]] = 1'b0;
			next_r.thaw = wqi_pkg::RST_WORD;
		end
		case (r.st)
			wqi_pkg::ST_IDLE: ;
			wqi_pkg::ST_EXEC:
			begin
				next_r.st = wqi_pkg::ST_DONE;
				if (r.code != wqi_pkg::CMD_INIT_WQ)
					next_r.status = {8'h00, wqi_pkg::ERR_BAD_CODE};
				else if (q_bad(r.blk.qnum, wide_variant)
					|| r.blk.qnum > 8'h0f)
					next_r.status = {8'h00, wqi_pkg::ERR_BAD_QUEUE};
				else if (pending[q])
					next_r.status = {8'h00, wqi_pkg::ERR_PENDING};
				else if (r.qf.inited[q] && !r.blk.qopt[wqi_pkg::QO_FORCE])
					next_r.status = {8'h00, wqi_pkg::ERR_ALREADY};
				else
				begin
					next_r.status = {8'h00, wqi_pkg::ERR_NONE};
					next_r.qf.inited[q] = 1'b1;
					next_r.qf.frozen[q] = 1'b0;
					next_r.qf.abort_en[q] = r.blk.qopt[wqi_pkg::QO_ABORT];
					next_r.qf.freeze_en[q] = r.blk.qopt[wqi_pkg::QO_FREEZE];
					next_r.qf.parity_en[q] = r.blk.qopt[wqi_pkg::QO_PARITY];
					next_r.qf.sense_en[q] = r.blk.qopt[wqi_pkg::QO_SENSE];
					next_r.qf.report_en[q] = r.blk.qopt[wqi_pkg::QO_REPORT];
					next_r.qf.bus_sel[q] = r.blk.unit[wqi_pkg::UA_BUS];
					next_r.tmo_q[q] = r.blk.tmo;
					if (r.blk.unit[wqi_pkg::UA_EXT])
					begin
						next_r.ext_id = r.blk.unit[3:0];
						next_r.ext_lun = r.blk.unit[13:8];
					end
				end
			end
			wqi_pkg::ST_DONE:
			begin
				next_r.st = wqi_pkg::ST_IDLE;
				if (r.blk.cmd_opt[wqi_pkg::BIT_IRQ_EN])
				begin
					next_r.ir.irq = 1'b1;
					next_r.ir.level = r.blk.level;
					next_r.ir.vector = (r.status[7:0] == wqi_pkg::ERR_NONE)
						? r.blk.vectors[15:8] : r.blk.vectors[7:0];
				end
			end
			wqi_pkg::ST_RUN: ;
			default: next_r.st = wqi_pkg::ST_IDLE;
		endcase
		// command completion from the engine
		if (cmd_done)
		begin
			next_r.resp_word = '0;
			next_r.status = {cmd_scsi_status, wqi_pkg::ERR_NONE};
			if (cmd_scsi_status != 8'h00)
			begin
				if (r.qf.abort_en[cmd_queue])
					next_r.abort_p[cmd_queue] = 1'b1;
				// sense takes precedence, so no freeze
				if (r.qf.sense_en[cmd_queue])
					next_r.sense_p = 1'b1;
				else if (r.qf.freeze_en[cmd_queue])
				begin
					next_r.qf.frozen[cmd_queue] = 1'b1;
					next_r.resp_word[wqi_pkg::RESP_FROZEN] =
						r.qf.report_en[cmd_queue];
				end
			end
			if (cmd_queue == r.run_q)
				next_r.run_left = '0;
		end
		// one command timed at a time; the timer is coarse
		if (cmd_started && !cmd_done)
		begin
			next_r.run_q = cmd_queue;
			next_r.run_left = r.tmo_q[cmd_queue];
			next_r.tick = '0;
		end
		else if (r.run_left != 16'h0000)
		begin
			if (r.tick == 32'(TICK_CYCLES - 1))
			begin
				next_r.tick = '0;
				next_r.run_left = r.run_left - 16'h0001;
				if (r.run_left == 16'h0001)
				begin
					next_r.err_p = 1'b1;
					next_r.resp_word[wqi_pkg::RESP_TIMEOUT] = 1'b1;
					next_r.status = {8'h00, wqi_pkg::ERR_TIMEOUT};
				end
			end
			else
				next_r.tick = r.tick + 32'h0000_0001;
		end
		if (hsel && hready && htrans[1])
		begin
			next_r.addr = haddr[9:2];
			next_r.wr_pend = hwrite;
			next_r.rd_pend = !hwrite;
			case (haddr[9:2])
				wqi_pkg::OFS_STATUS:  next_r.rdata = {16'h0, r.status};
				wqi_pkg::OFS_CODE:    next_r.rdata = {16'h0, r.code};
				wqi_pkg::OFS_SLOTS:   next_r.rdata = {16'h0, r.slots};
				wqi_pkg::OFS_THAW:    next_r.rdata = {16'h0, r.thaw};
				wqi_pkg::OFS_EVENT:   next_r.rdata = {16'h0, r.resp_word};
				wqi_pkg::OFS_QSTATE:
					next_r.rdata = {r.qf.frozen, r.qf.inited};
				wqi_pkg::OFS_GO:
					next_r.rdata = {28'h0, r.st};
				wqi_pkg::OFS_VARIANT: next_r.rdata = {31'h0, wide_variant};
				wqi_pkg::OFS_RESULT:
					next_r.rdata = {18'h0, r.ext_lun, 4'h0, r.ext_id};
				wqi_pkg::OFS_IRQ:
					next_r.rdata = {21'h0, r.ir.level, r.ir.vector};
				default:              next_r.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r <= '{st: wqi_pkg::ST_IDLE, tmo_q: '0, default: '0};
		end
		else
			r <= next_r;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;
	assign q_abort = r.abort_p;
	assign q_parity = r.qf.parity_en;
	assign q_frozen = r.qf.frozen;
	assign q_bus_sel = r.qf.bus_sel;
	assign sense_req = r.sense_p;
	assign ctrl_err_irq = r.err_p;
	assign irq_level = r.ir.level;
	assign irq_vector = r.ir.vector;
	assign irq = r.ir.irq;
endmodule // wqi_core

// ==== bench/wqi_chk.sv ====
`timescale 1ns/1ps
module wqi_chk #(
	parameter int TICK_CYCLES = 4
) (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// watched ports
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        cmd_done,
	input wire logic        irq,
	input wire logic        sense_req,
	input wire logic        ctrl_err_irq,
	input wire logic [15:0] q_abort,
	input wire logic [15:0] q_frozen
);
	logic [2:0] done_d;
	// outputs are registered, so a cause lies one to three edges back
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			done_d <= 3'h0;
		else
			done_d <= {done_d[1:0], cmd_done};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_caused;
		|done_d;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_irq_pulse: assert property (irq |=> !irq)
		else $error("completion irq longer than one cycle");
	a_abort_pulse: assert property (|q_abort |=> q_abort == 16'h0000)
		else $error("abort pulse too long");
	a_abort_cause: assert property (|q_abort |-> s_caused)
		else $error("abort without finished command");
	a_freeze_cause: assert property
		(|(q_frozen & ~$past(q_frozen)) |-> s_caused)
		else $error("queue froze without finished command");
	a_sense_cause: assert property (sense_req |-> s_caused)
		else $error("sense request without finished command");
	a_sense_pulse: assert property (sense_req |=> !sense_req)
		else $error("sense request too long");
	a_err_pulse: assert property (ctrl_err_irq |=> !ctrl_err_irq)
		else $error("controller error pulse too long");
endmodule // wqi_chk

bind wqi_core wqi_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.cmd_done(cmd_done), .irq(irq), .sense_req(sense_req),
	.ctrl_err_irq(ctrl_err_irq), .q_abort(q_abort), .q_frozen(q_frozen)
);

// ==== bench/wqi_engine.sv ====
`timescale 1ns/1ps
module wqi_engine (
	// clock
	input  wire logic        hclk,
	// engine events
	output logic             wide_variant,
	output logic      [15:0] pending,
	output logic             cmd_done,
	output logic             cmd_started,
	output logic      [3:0]  cmd_queue,
	output logic      [7:0]  cmd_scsi_status
);
	initial
	begin
		{wide_variant, pending, cmd_done, cmd_started} = 19'h0;
		{cmd_queue, cmd_scsi_status} = 12'h0;
	end
	task automatic wide(input logic w);
		@(posedge hclk);
		wide_variant <= w;
	endtask
	task automatic pend(input logic [15:0] p);
		@(posedge hclk);
		pending <= p;
	endtask
	// qualifiers go stale after the pulse, never left showing old values
	task automatic ev(input logic [3:0] q, input logic [7:0] s, input bit st);
		@(posedge hclk);
		cmd_queue <= q;
		cmd_scsi_status <= s;
		cmd_done <= !st;
		cmd_started <= st;
		@(posedge hclk);
		{cmd_done, cmd_started} <= 2'h0;
		cmd_queue <= ~q;
		cmd_scsi_status <= ~s;
	endtask
endmodule // wqi_engine

// ==== bench/wqi_tb_top.sv ====
`timescale 1ns/1ps
module wqi_tb_top;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, irq_level, l_irq;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [15:0] pending, q_abort, q_parity, q_frozen, q_bus_sel;
	logic        wide_variant, cmd_done, cmd_started, sense_req;
	logic        ctrl_err_irq, irq;
	logic [3:0]  cmd_queue;
	logic [7:0]  cmd_scsi_status, irq_vector, v_irq;
	int          err_count, n_tests, n_irq, n_ab, n_sense, n_cerr, n0;
	assign hready = hreadyout;
	wqi_core #(.TICK_CYCLES(4)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wide_variant(wide_variant), .pending(pending),
		.cmd_done(cmd_done), .cmd_queue(cmd_queue),
		.cmd_scsi_status(cmd_scsi_status), .cmd_started(cmd_started),
		.q_abort(q_abort), .q_parity(q_parity), .q_frozen(q_frozen),
		.q_bus_sel(q_bus_sel), .sense_req(sense_req),
		.ctrl_err_irq(ctrl_err_irq), .irq_level(irq_level),
		.irq_vector(irq_vector), .irq(irq)
	);
	wqi_engine eng (
		.hclk(hclk), .wide_variant(wide_variant), .pending(pending),
		.cmd_done(cmd_done), .cmd_started(cmd_started),
		.cmd_queue(cmd_queue), .cmd_scsi_status(cmd_scsi_status)
	);
	initial
	begin
		hclk = 0;
		forever #2 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		if (irq === 1'b1)
		begin
			n_irq++;
			v_irq = irq_vector;
			l_irq = irq_level;
		end
		if (q_abort[1] === 1'b1) n_ab++;
		if (sense_req === 1'b1) n_sense++;
		if (ctrl_err_irq === 1'b1) n_cerr++;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrdy;
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hready !== 1'b1 && k < 50);
		if (k >= 50)
		begin
			err_count++;
			stop_test;
		end
	endtask
	// address phase held until ready, then data phase until ready again
	task automatic cyc(input bit w, input logic [7:0] i, input logic [31:0] d);
		@(posedge hclk);
		{hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
		haddr <= {22'h0, i, 2'h0};
		wrdy;
		{hsel, htrans} <= 3'h0;
		hwdata <= d;
		wrdy;
		r = hrdata;
	endtask
	// only the defined fields are written; reserved words stay zero
	task automatic wq(input logic [15:0] c, o, l, q, qo, t, x);
		cyc(1, wqi_pkg::OFS_CODE, c);
		cyc(1, wqi_pkg::OFS_CMD_OPT, o);
		cyc(1, wqi_pkg::OFS_VECTORS, 32'ha55a);
		cyc(1, wqi_pkg::OFS_LEVEL, l);
		cyc(1, wqi_pkg::OFS_QNUM, q);
		cyc(1, wqi_pkg::OFS_QOPT, qo);
		cyc(1, wqi_pkg::OFS_UNIT, 32'h05c9);
		cyc(1, wqi_pkg::OFS_TMO_LO, t);
		n0 = n_irq;
		cyc(1, wqi_pkg::OFS_GO, 32'h1);
		repeat (6) @(posedge hclk);
		cyc(0, wqi_pkg::OFS_STATUS, 0);
		chk("status", r[7:0], x);
		chk("irq count", n_irq - n0, o[0]);
		if (o[0])
		begin
			chk("vector", v_irq, x == 0 ? 8'ha5 : 8'h5a);
			chk("level", l_irq, l);
		end
	endtask
	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
		hsize = 3'h2;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		wq(16'h42, 1, 3, 1, 16'h002d, 0, 0);
		chk("parity", q_parity[1], 1);
		chk("bus", q_bus_sel[1], 1);
		cyc(0, wqi_pkg::OFS_RESULT, 0);
		chk("unit", r[15:0], 16'h0509);
		$display("test init done");
		wq(16'h41, 1, 7, 2, 0, 0, 1);
		wq(16'h42, 1, 5, 0, 0, 0, 2);
		wq(16'h42, 1, 2, 15, 0, 0, 2);
		wq(16'h42, 0, 0, 1, 16'h002d, 0, 4);
		eng.pend(16'h0002);
		wq(16'h42, 1, 1, 1, 16'h802d, 0, 3);
		eng.pend(16'h0000);
		wq(16'h42, 1, 4, 1, 16'h802d, 0, 0);
		eng.wide(1'b1);
		wq(16'h42, 0, 0, 15, 0, 0, 0);
		wq(16'h42, 0, 0, 16'h20, 0, 0, 2);
		eng.wide(1'b0);
		$display("test errors done");
		eng.ev(1, 8'h02, 0);
		repeat (4) @(posedge hclk);
		chk("frozen", q_frozen[1], 1);
		chk("abort", n_ab > 0, 1);
		cyc(0, wqi_pkg::OFS_EVENT, 0);
		chk("frozen flag", r[3], 1);
		cyc(0, wqi_pkg::OFS_STATUS, 0);
		chk("passback", r[15:8], 8'h02);
		cyc(1, wqi_pkg::OFS_THAW, 32'h0101);
		cyc(0, wqi_pkg::OFS_THAW, 0);
		chk("thaw clear", r, 0);
		chk("thawed", q_frozen[1], 0);
		$display("test freeze done");
		wq(16'h42, 0, 0, 3, 16'h0014, 0, 0);
		eng.ev(3, 8'h02, 0);
		repeat (4) @(posedge hclk);
		chk("sense", n_sense, 1);
		chk("no freeze", q_frozen[3], 0);
		$display("test sense done");
		wq(16'h42, 0, 0, 2, 0, 1, 0);
		eng.ev(2, 0, 1);
		chk("early", n_cerr, 0);
		repeat (30) @(posedge hclk);
		chk("expired", n_cerr, 1);
		cyc(0, wqi_pkg::OFS_EVENT, 0);
		chk("timeout flag", r[7], 1);
		cyc(0, wqi_pkg::OFS_STATUS, 0);
		chk("timeout status", r[7:0], wqi_pkg::ERR_TIMEOUT);
		$display("test timeout done");
		stop_test;
	end
endmodule // wqi_tb_top
